/* File: hw/mbd_diag_exception.sv */
`timescale 1ns/100ps
module mbd_diag_exception (
	// Clock and reset.
	input  wire logic        clock,
	input  wire logic        nrst,
	// Configuration from the rest of the slave.
	input  wire logic [7:0]  slaveAddr,
	input  wire logic        commParamChange,
	// Received request summary, reqValid is a one-cycle pulse.
	input  wire logic        reqValid,
	input  wire logic [7:0]  reqAddr,
	input  wire logic [7:0]  reqFunc,
	input  wire logic [15:0] reqSubFunc,
	input  wire logic [15:0] reqData,
	input  wire logic        reqCommError,
	input  wire logic        reqOverrun,
	input  wire logic [7:0]  reqExcCode,
	// Byte stream towards the transmitter.
	input  wire logic        txReady,
	output logic             txValid,
	output logic      [7:0]  txByte,
	output logic             txLast,
	// Status towards the rest of the slave.
	output logic             passNormal,
	output logic             excIssued,
	output logic      [7:0]  lastExcCode,
	output logic             respIdle,
	output logic             reqDropped
);

	typedef enum {
		ST_IDLE,
		ST_SEND
	} mbd_state_e;

	// The whole state of the block sits in one packed record.
	// The next-state process fills a copy of it and one clocked process stores the copy.
	// The nine counters share one array so that the clear command and a change of line settings
	// can wipe them in a single assignment.
	// The frame store holds the six bytes that can come before the check value.
	// An exception frame uses only the first three of them.
	// The length field tells the sender how many stored bytes go out before the check value.
	// The send index counts the bytes that the transmitter has already taken.
	// The check value register follows the stored bytes as they are taken.
	// The byte after the last stored byte is therefore the low half of the finished check value.
	// The high half follows it one byte later, from the register itself.
	// The status pulses are cleared at the top of every cycle.
	// Each of them therefore stands for exactly one clock cycle.
	// The idle flag is kept as a flip-flop of its own.
	// Its output then never carries decoding glitches from the state compare.
	// It falls on the edge that starts a frame and rises on the edge that ends one.
	// It therefore always agrees with the state register.
	typedef struct packed {
		mbd_state_e               state;
		logic [8:0][15:0]         cnt;
		logic [5:0][7:0]          frame;
		logic [3:0]               len;
		logic [3:0]               sendIdx;
		logic [15:0]              crc;
		logic                     txValid;
		logic [7:0]               txByte;
		logic                     txLast;
		logic                     passNormal;
		logic                     excIssued;
		logic [7:0]               lastExcCode;
		logic                     reqDropped;
		logic                     respIdle;
	} mbd_regs_s;

	mbd_regs_s   r;
	mbd_regs_s   next_r;
	logic [15:0] crcAdv;

	// Check value of the frame so far with the byte now on the stream.
	mbd_crc16_byte crcStep (
		.crcIn  (r.crc),
		.dataIn (r.txByte),
		.crcOut (crcAdv)
	);

	// Only the clear command and the eight counter reads are served here.
	// Every other subfunction of the diagnostic function gets the illegal function code.
	// A user who adds subfunctions elsewhere must widen this test as well.
	// True when the request is a diagnostic subfunction that this block serves.
	function automatic logic diagKnown(input logic [15:0] sub);
		return (sub == mbd_pkg::SUB_CLEAR) ||
			((sub >= mbd_pkg::SUB_FIRST_CNT) && (sub <= mbd_pkg::SUB_LAST_CNT));
	endfunction

	// Next-state logic: request decoding, counting and frame sending.
	always_comb
	begin
		logic       isBcast;
		logic       forMe;
		logic       addrOk;
		logic [7:0] excCode;
		logic [3:0] nextIdx;
		logic [3:0] cntSel;
		isBcast = 1'b0;
		forMe   = 1'b0;
		addrOk  = 1'b0;
		excCode = mbd_pkg::EXC_NONE;
		nextIdx = 4'h0;
		cntSel  = 4'h0;
		next_r  = r;
		next_r.passNormal = 1'b0;
		next_r.excIssued  = 1'b0;
		next_r.reqDropped = 1'b0;

		// A change of line settings wipes the counters before this cycle's events.
		if (commParamChange)
			next_r.cnt = '0;

		unique case (r.state)
			ST_IDLE:
			begin
				if (reqValid)
				begin
					if (reqCommError)
					begin
						// Corrupted request: counted, never answered.
						next_r.cnt[mbd_pkg::CNT_BUS_ERR] = mbd_pkg::bump(next_r.cnt[mbd_pkg::CNT_BUS_ERR]);
						if (reqOverrun)
							next_r.cnt[mbd_pkg::CNT_OVERRUN] = mbd_pkg::bump(next_r.cnt[mbd_pkg::CNT_OVERRUN]);
						// No frame is started; the master falls back on its timeout.
					end
					else
					begin
						next_r.cnt[mbd_pkg::CNT_BUS_MSG] = mbd_pkg::bump(next_r.cnt[mbd_pkg::CNT_BUS_MSG]);
						addrOk  = (slaveAddr >= mbd_pkg::ADDR_MIN) && (slaveAddr <= mbd_pkg::ADDR_MAX);
						isBcast = (reqAddr == mbd_pkg::ADDR_BROADCAST);
						forMe   = addrOk && (reqAddr == slaveAddr);

						// Decide whether the request can be carried out.
						if (reqFunc == mbd_pkg::FUNC_DIAG)
						begin
							if (!diagKnown(reqSubFunc))
								excCode = mbd_pkg::EXC_ILL_FUNC;
							else if (reqData != 16'h0000)
								excCode = mbd_pkg::EXC_ILL_VALUE;
							else
								excCode = mbd_pkg::EXC_NONE;
						end
						else if (reqFunc == mbd_pkg::FUNC_EVENT_CNT)
							excCode = mbd_pkg::EXC_NONE;
						else
							excCode = reqExcCode;

						if (isBcast)
						begin
							// Broadcasts are counted and never answered.
							next_r.cnt[mbd_pkg::CNT_NO_RESP] = mbd_pkg::bump(next_r.cnt[mbd_pkg::CNT_NO_RESP]);
							if (excCode != mbd_pkg::EXC_NONE)
								next_r.cnt[mbd_pkg::CNT_EXC] = mbd_pkg::bump(next_r.cnt[mbd_pkg::CNT_EXC]);
						end
						else if (forMe)
						begin
							next_r.cnt[mbd_pkg::CNT_SLAVE_MSG] = mbd_pkg::bump(next_r.cnt[mbd_pkg::CNT_SLAVE_MSG]);
							next_r.frame[0] = slaveAddr;
							next_r.frame[1] = reqFunc;
							next_r.frame[2] = reqSubFunc[15:8];
							next_r.frame[3] = reqSubFunc[7:0];
							next_r.frame[4] = reqData[15:8];
							next_r.frame[5] = reqData[7:0];
							next_r.len      = mbd_pkg::LEN_ECHO;

							if (excCode != mbd_pkg::EXC_NONE)
							begin
								// Exception frame replaces the normal answer.
								next_r.cnt[mbd_pkg::CNT_EXC] = mbd_pkg::bump(next_r.cnt[mbd_pkg::CNT_EXC]);
								if (excCode == mbd_pkg::EXC_NAK)
									next_r.cnt[mbd_pkg::CNT_NAK] = mbd_pkg::bump(next_r.cnt[mbd_pkg::CNT_NAK]);
								if (excCode == mbd_pkg::EXC_BUSY)
									next_r.cnt[mbd_pkg::CNT_BUSY] = mbd_pkg::bump(next_r.cnt[mbd_pkg::CNT_BUSY]);
								next_r.frame[1]    = reqFunc | mbd_pkg::FUNC_EXC_FLAG;
								next_r.frame[2]    = excCode;
								next_r.len         = mbd_pkg::LEN_EXC;
								next_r.excIssued   = 1'b1;
								next_r.lastExcCode = excCode;
							end
							else if (reqFunc == mbd_pkg::FUNC_DIAG)
							begin
								if (reqSubFunc == mbd_pkg::SUB_CLEAR)
									next_r.cnt = '0;
								else
								begin
									// Subfunctions 11..18 map straight onto counters 0..7.
									cntSel = 4'(reqSubFunc - mbd_pkg::SUB_FIRST_CNT);
									next_r.frame[4] = r.cnt[cntSel][15:8];
									next_r.frame[5] = r.cnt[cntSel][7:0];
									next_r.cnt[mbd_pkg::CNT_EVENT] = mbd_pkg::bump(next_r.cnt[mbd_pkg::CNT_EVENT]);
								end
							end
							else if (reqFunc == mbd_pkg::FUNC_EVENT_CNT)
							begin
								// Status word, then the event counter; this read is not itself an event.
								next_r.frame[2] = mbd_pkg::EVENT_STATUS[15:8];
								next_r.frame[3] = mbd_pkg::EVENT_STATUS[7:0];
								next_r.frame[4] = r.cnt[mbd_pkg::CNT_EVENT][15:8];
								next_r.frame[5] = r.cnt[mbd_pkg::CNT_EVENT][7:0];
							end
							else
							begin
								// Normal answers to other functions come from elsewhere.
								next_r.passNormal = 1'b1;
								next_r.cnt[mbd_pkg::CNT_EVENT] = mbd_pkg::bump(next_r.cnt[mbd_pkg::CNT_EVENT]);
							end

							// Start sending when this block owns the answer.
							if ((excCode != mbd_pkg::EXC_NONE) || (reqFunc == mbd_pkg::FUNC_DIAG) ||
								(reqFunc == mbd_pkg::FUNC_EVENT_CNT))
							begin
								next_r.state   = ST_SEND;
								next_r.sendIdx = 4'h0;
								next_r.crc     = mbd_pkg::CRC_INIT;
								next_r.txValid = 1'b1;
								next_r.txByte  = slaveAddr;
								next_r.txLast  = 1'b0;
							end
						end
					end
				end
			end

			ST_SEND:
			begin
				// The transmitter may hold off any byte for as long as it likes.
				// Nothing moves until it takes the byte on the stream.
				// The byte and the last flag therefore stand unchanged while it stalls.
				// The check value is folded only while stored bytes are being taken.
				// It must not fold in the two check bytes themselves.
				// A request that comes while the frame goes out is neither counted nor answered.
				// Only the dropped pulse tells the rest of the slave that it was lost.
				// A request cannot be taken while a frame is still going out.
				if (reqValid)
					next_r.reqDropped = 1'b1;
				if (txReady)
				begin
					nextIdx        = r.sendIdx + 4'h1;
					next_r.sendIdx = nextIdx;
					if (r.sendIdx < r.len)
						next_r.crc = crcAdv;
					if (nextIdx < r.len)
						next_r.txByte = r.frame[3'(nextIdx)];
					else if (nextIdx == r.len)
						next_r.txByte = crcAdv[7:0];
					else if (nextIdx == r.len + 4'h1)
					begin
						next_r.txByte = r.crc[15:8];
						next_r.txLast = 1'b1;
					end
					else
					begin
						// Last check byte accepted; the frame is done.
						next_r.state   = ST_IDLE;
						next_r.txValid = 1'b0;
						next_r.txLast  = 1'b0;
					end
				end
			end
		endcase

		// The idle flag follows the state that is about to be stored.
		next_r.respIdle = (next_r.state == ST_IDLE);
	end

	// Reset clears every counter, as a loss of power must.
	// The check value restarts from its initial value, so a frame never starts from stale bits.
	// After reset the block is idle and may take a request in the very next cycle.
	// State register; reset stands for a loss of power.
	always_ff @(posedge clock)
	begin
		if (!nrst)
		begin
			r             <= '0;
			r.state       <= ST_IDLE;
			r.cnt         <= {mbd_pkg::CNT_NUM{mbd_pkg::CNT_RESET}};
			r.crc         <= mbd_pkg::CRC_INIT;
			r.lastExcCode <= mbd_pkg::EXC_NONE;
			r.respIdle    <= 1'b1;
		end
		else
			r <= next_r;
	end

	// Every output is a plain copy of one flip-flop in the state record.
	// The rest of the slave can sample them at any edge without a settling hazard.
	// The last exception code stands until the next exception frame starts.
	// Outputs straight from the state register.
	assign txValid     = r.txValid;
	assign txByte      = r.txByte;
	assign txLast      = r.txLast;
	assign passNormal  = r.passNormal;
	assign excIssued   = r.excIssued;
	assign lastExcCode = r.lastExcCode;
	assign respIdle    = r.respIdle;
	assign reqDropped  = r.reqDropped;

endmodule

/* File: hw/mbd_pkg.sv */
// Shared constants of the diagnostic and exception block.
package mbd_pkg;

	// Function codes handled here.
	localparam logic [7:0]  FUNC_DIAG       = 8'h08;
	localparam logic [7:0]  FUNC_EVENT_CNT  = 8'h0b;
	localparam logic [7:0]  FUNC_EXC_FLAG   = 8'h80;

	// Diagnostic subfunctions.
	localparam logic [15:0] SUB_CLEAR       = 16'h000a;
	localparam logic [15:0] SUB_FIRST_CNT   = 16'h000b;
	localparam logic [15:0] SUB_LAST_CNT    = 16'h0012;

	// Exception codes.
	localparam logic [7:0]  EXC_NONE        = 8'h00;
	localparam logic [7:0]  EXC_ILL_FUNC    = 8'h01;
	localparam logic [7:0]  EXC_ILL_ADDR    = 8'h02;
	localparam logic [7:0]  EXC_ILL_VALUE   = 8'h03;
	localparam logic [7:0]  EXC_DEV_FAIL    = 8'h04;
	localparam logic [7:0]  EXC_ACK         = 8'h05;
	localparam logic [7:0]  EXC_BUSY        = 8'h06;
	localparam logic [7:0]  EXC_NAK         = 8'h07;
	localparam logic [7:0]  EXC_MEM_PARITY  = 8'h08;
	localparam logic [7:0]  EXC_GW_PATH     = 8'h0a;
	localparam logic [7:0]  EXC_GW_TARGET   = 8'h0b;

	// Counter positions in the counter array.
	localparam int          CNT_BUS_MSG     = 0;
	localparam int          CNT_BUS_ERR     = 1;
	localparam int          CNT_EXC         = 2;
	localparam int          CNT_SLAVE_MSG   = 3;
	localparam int          CNT_NO_RESP     = 4;
	localparam int          CNT_NAK         = 5;
	localparam int          CNT_BUSY        = 6;
	localparam int          CNT_OVERRUN     = 7;
	localparam int          CNT_EVENT       = 8;
	localparam int          CNT_NUM         = 9;

	// Slave address limits.
	localparam logic [7:0]  ADDR_BROADCAST  = 8'h00;
	localparam logic [7:0]  ADDR_MIN        = 8'h01;
	localparam logic [7:0]  ADDR_MAX        = 8'hf7;

	// Frame sizes in bytes, check value excluded.
	localparam logic [3:0]  LEN_EXC         = 4'h3;
	localparam logic [3:0]  LEN_ECHO        = 4'h6;
	localparam int          FRAME_BYTES     = 6;

	// Check value and reset values.
	localparam logic [15:0] CRC_INIT        = 16'hffff;
	localparam logic [15:0] CRC_POLY        = 16'ha001;
	localparam logic [15:0] CNT_RESET       = 16'h0000;
	localparam logic [15:0] EVENT_STATUS    = 16'h0000;

	// A counter step; the full value rolls over to zero.
	function automatic logic [15:0] bump(input logic [15:0] v);
		return v + 16'h0001;
	endfunction

endpackage

/* File: hw/mbd_crc16_byte.sv */
`timescale 1ns/100ps
// Folds one byte into the frame check value, least significant bit first.
module mbd_crc16_byte (
	// Running check value and new byte.
	input  wire logic [15:0] crcIn,
	input  wire logic [7:0]  dataIn,
	// Updated check value.
	output logic      [15:0] crcOut
);

	// Eight shift steps of the reflected polynomial.
	always_comb
	begin
		logic [15:0] c;
		c = crcIn ^ {8'h00, dataIn};
		for (int i = 0; i < 8; i++)
		begin
			if (c[0])
				c = (c >> 1) ^ mbd_pkg::CRC_POLY;
			else
				c = c >> 1;
		end
		crcOut = c;
	end

endmodule

/* File: testbench/mbd_chk.sv */
`timescale 1ns/100ps
// Watches the reply stream and the status pulses at the block's ports.
module mbd_chk (
	// Watched ports.
	input wire logic       clock, nrst, reqValid, reqCommError, txReady, txValid,
	input wire logic       txLast, passNormal, excIssued, respIdle, reqDropped,
	input wire logic [7:0] slaveAddr, reqAddr, reqFunc, reqExcCode, txByte, lastExcCode
);
	logic [7:0] func;
	logic [3:0] idx;
	logic       exc;
	logic       take;
	// A request counts as taken only while the block is idle.
	assign take = reqValid && respIdle;
	// Keeps the taken function, the frame kind and the byte position.
	always_ff @(posedge clock)
	begin
		if (!nrst)
		begin
			idx <= 4'h0;
			exc <= 1'b0;
		end
		else
		begin
			if (take)
				func <= reqFunc;
			if (excIssued)
				exc <= 1'b1;
			else if (txValid && txReady && txLast)
				exc <= 1'b0;
			if (txValid && txReady)
				idx <= txLast ? 4'h0 : idx + 4'h1;
		end
	end
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!nrst);
	property p_excStart;
		excIssued |-> txValid && txByte == slaveAddr;
	endproperty
	a_excStart: assert property (p_excStart) else $error("exception frame opens badly");
	property p_excFunc;
		exc && txValid && idx == 4'h1 |-> txByte == (func | 8'h80);
	endproperty
	a_excFunc: assert property (p_excFunc) else $error("exception function byte wrong");
	property p_excCode;
		exc && txValid && idx == 4'h2 |-> txByte == lastExcCode && !txLast;
	endproperty
	a_excCode: assert property (p_excCode) else $error("exception code byte wrong");
	property p_excLen;
		exc && txValid && txLast |-> idx == 4'h4;
	endproperty
	a_excLen: assert property (p_excLen) else $error("exception frame length wrong");
	property p_silent;
		take && reqCommError |=> !txValid && !passNormal && !excIssued;
	endproperty
	a_silent: assert property (p_silent) else $error("corrupt request answered");
	property p_event;
		take && !reqCommError && reqAddr == slaveAddr && reqFunc == 8'h0b |=> txValid && !excIssued;
	endproperty
	a_event: assert property (p_event) else $error("event counter read not answered");
	property p_pass;
		take && !reqCommError && reqAddr == slaveAddr && reqFunc == 8'h03
			|=> ($past(reqExcCode) == 8'h00 ? passNormal && !excIssued : excIssued && !passNormal);
	endproperty
	a_pass: assert property (p_pass) else $error("normal or exception choice wrong");
	property p_hold;
		txValid && !txReady |=> txValid && $stable(txByte) && $stable(txLast);
	endproperty
	a_hold: assert property (p_hold) else $error("stalled byte changed");
	property p_refuse;
		reqValid && !respIdle |=> reqDropped && !excIssued && !passNormal;
	endproperty
	a_refuse: assert property (p_refuse) else $error("busy request not dropped");
endmodule
bind mbd_diag_exception mbd_chk i_mbd_chk (.clock, .nrst, .reqValid, .reqCommError, .txReady, .txValid, .txLast,
	.passNormal, .excIssued, .respIdle, .reqDropped, .slaveAddr, .reqAddr, .reqFunc, .reqExcCode, .txByte, .lastExcCode);

/* File: testbench/mbd_master_model.sv */
`timescale 1ns/100ps
// Polling master: takes reply bytes, stalls when told, checks the check value.
module mbd_master_model (
	// Reply stream.
	input wire logic         clock, txValid, txLast, stall,
	input wire logic [7:0]   txByte,
	output logic             txReady,
	// Last frame seen.
	output logic [15:0][7:0] rx,
	output int               nf, len,
	output logic             crcOk
);
	int cnt = 0;
	initial
	begin
		txReady = 1'b1;
		nf = 0;
	end
	// Stalling halves the pace; a closed frame has its check value recomputed.
	always @(posedge clock)
	begin
		logic [15:0] c;
		txReady <= stall ? !txReady : 1'b1;
		if (txValid && txReady)
		begin
			rx[cnt] = txByte;
			cnt++;
			if (txLast)
			begin
				c = 16'hffff;
				for (int i = 0; i < cnt - 2; i++)
				begin
					c ^= {8'h00, rx[i]};
					repeat (8) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
				end
				crcOk = c === {rx[cnt - 1], rx[cnt - 2]};
				len = cnt;
				nf++;
				cnt = 0;
			end
		end
	end
endmodule

/* File: testbench/mbd_diag_exception_test.sv */
`timescale 1ns/100ps
// Drives request summaries and judges replies, counters and status pulses.
module mbd_diag_exception_test;
	logic             clock = 1'b0, nrst = 1'b0, commParamChange = 1'b0, reqValid = 1'b0, stall = 1'b0;
	logic             reqCommError = 1'b0, reqOverrun = 1'b0, txReady, txValid, txLast;
	logic             passNormal, excIssued, respIdle, reqDropped, crcOk, pn, ei, dr;
	logic [7:0]       slaveAddr = 8'h11, reqAddr = 8'h00, reqFunc = 8'h00, reqExcCode = 8'h00, txByte, lastExcCode;
	logic [15:0]      reqSubFunc = 16'h0000, reqData = 16'h0000;
	logic [15:0][7:0] rx;
	int               n_fail = 0, n_checks = 0, cyc = 0, nf, nf0, len;
	// Block and the polling master.
	mbd_diag_exception i_mbd_diag_exception (.clock, .nrst, .slaveAddr, .commParamChange, .reqValid, .reqAddr,
		.reqFunc, .reqSubFunc, .reqData, .reqCommError, .reqOverrun, .reqExcCode, .txReady, .txValid, .txByte,
		.txLast, .passNormal, .excIssued, .lastExcCode, .respIdle, .reqDropped);
	mbd_master_model i_mbd_master_model (.clock, .txValid, .txLast, .stall, .txByte, .txReady, .rx, .nf, .len, .crcOk);
	// Clock and hang guard.
	initial forever #20 clock = !clock;
	always @(posedge clock)
	begin
		cyc++;
		if (cyc == 90000)
		begin
			n_fail++;
			final_report;
		end
	end
	task automatic check(input string what, input logic [15:0] seen, exp);
		n_checks++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask
	task automatic final_report;
		$display("checks %0d, mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// One request pulse; the status pulses of the next cycle are kept.
	task automatic send(input logic [7:0] a, f, e, input logic [15:0] s, input logic [1:0] err);
		nf0 = nf;
		@(posedge clock);
		reqValid <= 1'b1;
		reqAddr <= a;
		reqFunc <= f;
		reqExcCode <= e;
		reqSubFunc <= s;
		reqCommError <= err[0];
		reqOverrun <= err[1];
		@(posedge clock);
		reqValid <= 1'b0;
		#1;
		pn = passNormal;
		ei = excIssued;
		dr = reqDropped;
	endtask
	task automatic frame(input int n);
		for (int i = 0; i < 200 && nf == nf0; i++)
		begin
			@(posedge clock);
			#1;
		end
		check("frame seen", 16'(nf - nf0), 16'h0001);
		check("frame length", 16'(len), 16'(n));
		check("slave number", rx[0], slaveAddr);
		check("check value", crcOk, 1'b1);
	endtask
	// The master sees no reply frame close in the next twenty cycles.
	task automatic quiet;
		repeat (20) @(posedge clock);
		check("no reply", 16'(nf - nf0), 16'h0000);
	endtask
	task automatic rd(input logic [15:0] s, exp);
		send(slaveAddr, 8'h08, 8'h00, s, 2'b00);
		frame(8);
		check("echoed subfunction", {rx[2], rx[3]}, s);
		check("counter word", {rx[4], rx[5]}, exp);
	endtask
	task automatic t_count;
		logic [15:0] want [8] = '{16'h7, 16'h2, 16'h3, 16'h9, 16'h1, 16'h1, 16'h1, 16'h1};
		rd(16'h000a, 16'h0000);
		rd(16'h000b, 16'h0000);
		send(slaveAddr, 8'h03, 8'h00, 16'h0000, 2'b00);
		check("normal pass", pn, 1'b1);
		send(slaveAddr, 8'h03, 8'h00, 16'h0000, 2'b11);
		quiet;
		send(slaveAddr, 8'h03, 8'h00, 16'h0000, 2'b01);
		quiet;
		send(8'h00, 8'h06, 8'h00, 16'h0000, 2'b00);
		quiet;
		send(slaveAddr, 8'h03, 8'h06, 16'h0000, 2'b00);
		frame(5);
		check("busy code", rx[2], 8'h06);
		send(slaveAddr, 8'h03, 8'h00, 16'h0000, 2'b00);
		check("retry pass", pn, 1'b1);
		send(slaveAddr, 8'h10, 8'h07, 16'h0000, 2'b00);
		frame(5);
		check("exception function", rx[1], 8'h90);
		send(slaveAddr, 8'h08, 8'h00, 16'h0013, 2'b00);
		frame(5);
		check("unknown subfunction", rx[2], 8'h01);
		for (int i = 0; i < 8; i++)
			rd(16'h000b + 16'(i), want[i]);
		send(slaveAddr, 8'h0b, 8'h00, 16'h0000, 2'b00);
		frame(8);
		check("event counter", {rx[4], rx[5]}, 16'h000b);
		$display("t_count done");
	endtask
	// Every code but 06 and 07, with the master stalling and a request refused mid-frame.
	task automatic t_codes;
		logic [7:0] codes [8] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h08, 8'h0a, 8'h0b};
		stall <= 1'b1;
		for (int i = 0; i < 8; i++)
		begin
			send(slaveAddr, 8'h03, codes[i], 16'h0000, 2'b00);
			check("exception start", ei, 1'b1);
			if (i == 0)
			begin
				send(slaveAddr, 8'h03, 8'h00, 16'h0000, 2'b00);
				check("refused request", dr, 1'b1);
			end
			frame(5);
			check("exception code", rx[2], codes[i]);
			check("last code", lastExcCode, codes[i]);
		end
		stall <= 1'b0;
		$display("t_codes done");
	endtask
	// Parameter change clears, then broadcasts run two counters past their top.
	task automatic t_roll;
		@(posedge clock);
		commParamChange <= 1'b1;
		@(posedge clock);
		commParamChange <= 1'b0;
		rd(16'h000d, 16'h0000);
		rd(16'h000a, 16'h0000);
		@(posedge clock);
		reqValid <= 1'b1;
		reqAddr <= 8'h00;
		reqFunc <= 8'h06;
		repeat (65537) @(posedge clock);
		reqValid <= 1'b0;
		rd(16'h000f, 16'h0001);
		rd(16'h000b, 16'h0002);
		$display("t_roll done");
	endtask
	initial
	begin
		repeat (20) @(posedge clock);
		nrst <= 1'b1;
		@(posedge clock);
		#1;
		check("idle after reset", respIdle, 1'b1);
		check("stream quiet after reset", txValid, 1'b0);
		rd(16'h000e, 16'h0000);
		t_count;
		t_codes;
		t_roll;
		final_report;
	end
endmodule
